// file: rtl/jmw_regs.vh
// Constants for the mailbox flash word writer
`ifndef JMW_REGS_VH
`define JMW_REGS_VH
`define JMW_DATA_W        16
`define JMW_ADDR_W        20
`define JMW_FIFO_DEPTH    4
// Mailbox words
`define JMW_INPUT_REQUEST 16'h0001
`define JMW_POLL_WORD     16'h0000
`define JMW_READY_BIT     0
// Mailbox exchange instruction, first-shifted bit in bit 0 (value arbitrary, set per target)
`define JMW_MAILBOX_EXCHANGE_INSTRUCTION 8'h61
// Shift sequences from Run-Test/Idle back to Run-Test/Idle
`define JMW_IR_BITS       5'd14
`define JMW_IR_TMS        21'h001803
`define JMW_DR_BITS       5'd21
`define JMW_DR_TMS        21'h0C0001
`define JMW_DR_CAP_FIRST  5'd3
`define JMW_DR_CAP_LAST   5'd18
// Link clock: half period in system clocks (4 -> 160 ns period at 50 MHz)
`define JMW_TCK_HALF      3'd4
// Test clock cycles after each word and longest word programming time
`define JMW_TEST_CLOCKS   30
`define JMW_TWORD_MAX_US  100
`define JMW_CLK_MHZ       50
`endif

// file: rtl/jmw_fifo.v
// Small FIFO in the data word path
`timescale 1ns/1ps
`default_nettype none
module jmw_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             clk,
	input  wire             rst,
	input  wire             in_valid,
	input  wire [WIDTH-1:0] in_data,
	output wire             in_ready,
	output wire             out_valid,
	output wire [WIDTH-1:0] out_data,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_ptr;
	reg [AW:0]      rd_ptr;
	wire            full;
	wire            empty;

	// Full when pointers differ only in the wrap bit
	assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign empty     = (wr_ptr == rd_ptr);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	// Write side
	always @(posedge clk) begin
		if (rst) begin
			wr_ptr <= {(AW+1){1'b0}};
		end else if (in_valid && !full) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	// Read side
	always @(posedge clk) begin
		if (rst) begin
			rd_ptr <= {(AW+1){1'b0}};
		end else if (out_ready && !empty) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule // jmw_fifo
`default_nettype wire

// file: rtl/jmw_writer.v
// Host sequencer feeding flash words to target code through the JTAG mailbox
`timescale 1ns/1ps
`default_nettype none
`include "jmw_regs.vh"
module jmw_writer #(
	parameter TWORD_CYCLES = `JMW_TWORD_MAX_US * `JMW_CLK_MHZ
) (
	input  wire                   SYS_CLK,
	input  wire                   SYS_RST,
	input  wire                   START,
	input  wire                   MODE_FREE,
	input  wire [15:0]            WORD_COUNT,
	input  wire [`JMW_ADDR_W-1:0] FIRST_WRITE_ADDRESS,
	input  wire [15:0]            FLASH_CONTROL_THIRD_VALUE,
	input  wire [`JMW_ADDR_W-1:0] IMAGE_BASE,
	input  wire [15:0]            IMAGE_OFFSET,
	input  wire                   LOAD_DONE,
	input  wire                   IN_VALID,
	input  wire [`JMW_DATA_W-1:0] IN_DATA,
	output wire                   IN_READY,
	output reg                    LOAD_REQ,
	output reg [`JMW_ADDR_W-1:0]  PARAM_ADDRESS,
	output reg [15:0]             PARAM_LENGTH,
	output reg [15:0]             PARAM_FLASH_CONTROL,
	output reg [`JMW_ADDR_W-1:0]  CODE_ENTRY,
	output reg                    RELEASE_REQ,
	output reg                    HALT_REQ,
	output reg                    BUSY,
	output reg                    DONE,
	output reg                    TCK,
	output reg                    TMS,
	output reg                    TDI,
	input  wire                   TDO
);
	// Test clock half period: 60 half periods must cover the longest word time
	localparam [31:0] TEST_HALFS = 2 * `JMW_TEST_CLOCKS;
	localparam [31:0] HALF_CYC   = (TWORD_CYCLES + TEST_HALFS - 1) / TEST_HALFS;
	localparam [15:0] HALF_LOAD  = (HALF_CYC < 32'd1) ? 16'd1 : HALF_CYC[15:0];
	localparam [5:0]  HALF_COUNT = TEST_HALFS[5:0];

	localparam [8:0] S_IDLE = 9'h001;
	localparam [8:0] S_LOAD = 9'h002;
	localparam [8:0] S_WORD = 9'h004;
	localparam [8:0] S_IR   = 9'h008;
	localparam [8:0] S_REQ  = 9'h010;
	localparam [8:0] S_DATA = 9'h020;
	localparam [8:0] S_TEST = 9'h040;
	localparam [8:0] S_POLL = 9'h080;
	localparam [8:0] S_END  = 9'h100;

	reg  [8:0]             state;
	reg                    free_mode;
	reg  [15:0]            words_left;
	reg  [`JMW_DATA_W-1:0] word;
	reg                    tdo_meta;
	reg                    tdo_sync;
	reg  [2:0]             div;
	reg                    sh_busy;
	reg                    sh_go;
	reg                    sh_done;
	reg                    sh_cap_en;
	reg  [20:0]            sh_tms;
	reg  [20:0]            sh_tdi;
	reg  [4:0]             sh_len;
	reg  [4:0]             sh_idx;
	reg  [15:0]            captured_output_word;
	reg  [15:0]            half_cnt;
	reg  [5:0]             halfs_left;
	reg                    cpu_test_clock_level;
	reg                    pop;
	wire                   fifo_valid;
	wire [`JMW_DATA_W-1:0] fifo_data;
	wire                   tick;

	// Reverse a word so the most significant bit leaves first
	function [15:0] msb_first;
		input [15:0] w;
		integer i;
		begin
			for (i = 0; i < 16; i = i + 1) begin
				msb_first[i] = w[15 - i];
			end
		end
	endfunction

	// Data words wait here until the sequencer asks for one
	jmw_fifo #(
		.WIDTH (`JMW_DATA_W),
		.DEPTH (`JMW_FIFO_DEPTH),
		.AW    (2)
	) u_fifo (
		.clk       (SYS_CLK),
		.rst       (SYS_RST),
		.in_valid  (IN_VALID),
		.in_data   (IN_DATA),
		.in_ready  (IN_READY),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (pop)
	);

	// Two-stage synchroniser for the returning link data
	always @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			tdo_meta <= 1'b0;
			tdo_sync <= 1'b0;
		end else begin
			tdo_meta <= TDO;
			tdo_sync <= tdo_meta;
		end
	end

	// Link clock divider: one enable per half period while shifting
	assign tick = sh_busy && (div == `JMW_TCK_HALF - 3'd1);
	always @(posedge SYS_CLK) begin
		if (SYS_RST || !sh_busy) begin
			div <= 3'd0;
		end else if (tick) begin
			div <= 3'd0;
		end else begin
			div <= div + 3'd1;
		end
	end

	// Shift engine: TMS/TDI change with TCK low, TDO sampled before each fall of DR shift bits 3 to 18
	always @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			sh_busy              <= 1'b0;
			sh_done              <= 1'b0;
			sh_idx               <= 5'd0;
			TCK                  <= 1'b0;
			TMS                  <= 1'b0;
			captured_output_word <= 16'h0000;
		end else begin
			sh_done <= 1'b0;
			if (sh_go && !sh_busy) begin
				sh_busy <= 1'b1;
				sh_idx  <= 5'd0;
				TMS     <= sh_tms[0];
			end else if (tick && !TCK) begin
				TCK <= 1'b1;
			end else if (tick && TCK) begin
				TCK <= 1'b0;
				if (sh_cap_en && sh_idx >= `JMW_DR_CAP_FIRST && sh_idx <= `JMW_DR_CAP_LAST) begin
					captured_output_word <= {captured_output_word[14:0], tdo_sync};
				end
				if (sh_idx == sh_len - 5'd1) begin
					sh_busy <= 1'b0;
					sh_done <= 1'b1;
					TMS     <= 1'b0;
				end else begin
					sh_idx <= sh_idx + 5'd1;
					TMS    <= sh_tms[sh_idx + 5'd1];
				end
			end
		end
	end

	// TDI carries shift data during shifts and the CPU test clock in idle
	always @(*) begin
		if (sh_busy) begin
			TDI = sh_tdi[sh_idx];
		end else begin
			TDI = cpu_test_clock_level;
		end
	end

	// Main sequencer
	always @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			state               <= S_IDLE;
			free_mode           <= 1'b0;
			words_left          <= 16'h0000;
			word                <= 16'h0000;
			sh_go               <= 1'b0;
			sh_cap_en           <= 1'b0;
			sh_len              <= 5'd0;
			sh_tms              <= 21'h000000;
			sh_tdi              <= 21'h000000;
			half_cnt            <= 16'h0000;
			halfs_left          <= 6'd0;
			cpu_test_clock_level          <= 1'b0;
			pop                 <= 1'b0;
			LOAD_REQ            <= 1'b0;
			PARAM_ADDRESS       <= {`JMW_ADDR_W{1'b0}};
			PARAM_LENGTH        <= 16'h0000;
			PARAM_FLASH_CONTROL <= 16'h0000;
			CODE_ENTRY          <= {`JMW_ADDR_W{1'b0}};
			RELEASE_REQ         <= 1'b0;
			HALT_REQ            <= 1'b0;
			BUSY                <= 1'b0;
			DONE                <= 1'b0;
		end else begin
			sh_go    <= 1'b0;
			pop      <= 1'b0;
			HALT_REQ <= 1'b0;
			DONE     <= 1'b0;
			case (state)
				S_IDLE: begin
					if (START) begin
						free_mode           <= MODE_FREE;
						words_left          <= WORD_COUNT;
						PARAM_ADDRESS       <= FIRST_WRITE_ADDRESS;
						PARAM_LENGTH        <= WORD_COUNT;
						PARAM_FLASH_CONTROL <= FLASH_CONTROL_THIRD_VALUE;
						// Entry point is the offset word's own address plus the offset
						CODE_ENTRY          <= IMAGE_BASE + {{(`JMW_ADDR_W-16){1'b0}}, IMAGE_OFFSET};
						LOAD_REQ            <= 1'b1;
						BUSY                <= 1'b1;
						state               <= S_LOAD;
					end
				end
				S_LOAD: begin
					// Loader places the image and parameter area, then starts the code
					if (LOAD_DONE) begin
						LOAD_REQ    <= 1'b0;
						RELEASE_REQ <= free_mode;
						state       <= (words_left == 16'h0000) ? S_END : S_WORD;
					end
				end
				S_WORD: begin
					if (fifo_valid) begin
						word      <= fifo_data;
						pop       <= 1'b1;
						sh_tms    <= `JMW_IR_TMS;
						sh_tdi    <= {9'h000, `JMW_MAILBOX_EXCHANGE_INSTRUCTION, 4'h0};
						sh_len    <= `JMW_IR_BITS;
						sh_cap_en <= 1'b0;
						sh_go     <= 1'b1;
						state     <= S_IR;
					end
				end
				S_IR: begin
					if (sh_done) begin
						sh_tms    <= `JMW_DR_TMS;
						sh_tdi    <= {2'b00, msb_first(`JMW_INPUT_REQUEST), 3'b000};
						sh_len    <= `JMW_DR_BITS;
						sh_cap_en <= 1'b1;
						sh_go     <= 1'b1;
						state     <= S_REQ;
					end
				end
				S_REQ: begin
					if (sh_done) begin
						sh_tdi <= {2'b00, msb_first(word), 3'b000};
						sh_go  <= 1'b1;
						state  <= S_DATA;
					end
				end
				S_DATA: begin
					if (sh_done) begin
						words_left <= words_left - 16'h0001;
						if (free_mode) begin
							sh_tdi <= {2'b00, msb_first(`JMW_POLL_WORD), 3'b000};
							sh_go  <= 1'b1;
							state  <= S_POLL;
						end else begin
							half_cnt   <= HALF_LOAD;
							halfs_left <= HALF_COUNT;
							state      <= S_TEST;
						end
					end
				end
				S_TEST: begin
					// Test clock toggles on TDI in idle; its 60 half periods pace the target's flash timing
					if (half_cnt > 16'h0001) begin
						half_cnt <= half_cnt - 16'h0001;
					end else if (halfs_left != 6'd0) begin
						cpu_test_clock_level <= !cpu_test_clock_level;
						halfs_left <= halfs_left - 6'd1;
						half_cnt   <= HALF_LOAD;
					end else begin
						state <= (words_left == 16'h0000) ? S_END : S_WORD;
					end
				end
				S_POLL: begin
					// Progress in free mode is seen only through the polled word
					if (sh_done) begin
						if (captured_output_word[`JMW_READY_BIT]) begin
							state <= (words_left == 16'h0000) ? S_END : S_WORD;
						end else begin
							sh_go <= 1'b1;
						end
					end
				end
				S_END: begin
					// Code sits in its final loop; take target back to halted emulation
					RELEASE_REQ <= 1'b0;
					HALT_REQ    <= 1'b1;
					BUSY        <= 1'b0;
					DONE        <= 1'b1;
					state       <= S_IDLE;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end
endmodule // jmw_writer
`default_nettype wire

// file: tb/jmw_writer_asserts.sv
// Port checker for the mailbox flash word writer
`timescale 1ns/1ps
`default_nettype none
module jmw_writer_asserts (
	input wire logic        SYS_CLK,
	input wire logic        SYS_RST,
	input wire logic        START,
	input wire logic        MODE_FREE,
	input wire logic [15:0] WORD_COUNT,
	input wire logic [19:0] FIRST_WRITE_ADDRESS,
	input wire logic [15:0] FLASH_CONTROL_THIRD_VALUE,
	input wire logic [19:0] IMAGE_BASE,
	input wire logic [15:0] IMAGE_OFFSET,
	input wire logic        LOAD_REQ,
	input wire logic [19:0] PARAM_ADDRESS,
	input wire logic [15:0] PARAM_LENGTH,
	input wire logic [15:0] PARAM_FLASH_CONTROL,
	input wire logic [19:0] CODE_ENTRY,
	input wire logic        RELEASE_REQ,
	input wire logic        HALT_REQ,
	input wire logic        BUSY,
	input wire logic        DONE,
	input wire logic        TCK,
	input wire logic        TMS
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	// A start that is taken
	wire take = START && !BUSY;
	AST_LOAD: assert property (take |=> LOAD_REQ && BUSY) else $error("no load request");
	AST_PARAM: assert property (take |=> PARAM_ADDRESS == $past(FIRST_WRITE_ADDRESS) &&
		PARAM_LENGTH == $past(WORD_COUNT) && PARAM_FLASH_CONTROL == $past(FLASH_CONTROL_THIRD_VALUE))
		else $error("parameters wrong");
	AST_ENTRY: assert property (take |=> CODE_ENTRY == $past(IMAGE_BASE) + $past(IMAGE_OFFSET))
		else $error("entry wrong");
	AST_REFUSE: assert property (START && BUSY |=> $stable(PARAM_LENGTH)) else $error("busy start taken");
	AST_END: assert property (DONE |-> HALT_REQ ##1 !BUSY && !DONE) else $error("bad end");
	AST_HALT: assert property (HALT_REQ |-> DONE) else $error("halt outside end");
	AST_TCKHI: assert property ($rose(TCK) |-> TCK[*4] ##1 !TCK) else $error("link high time");
	AST_TMS: assert property (TCK |-> $stable(TMS)) else $error("mode moved with clock high");
	AST_IDLE: assert property (!BUSY && !$past(BUSY) |-> !TCK && !RELEASE_REQ) else $error("idle activity");
	AST_CTRL: assert property (take && !MODE_FREE |=> !RELEASE_REQ[*8]) else $error("released");
	AST_LOADQ: assert property (LOAD_REQ |-> !TCK) else $error("link before load");
	cover property (take && MODE_FREE);
	cover property (take && !MODE_FREE);
	cover property (START && BUSY);
endmodule // jmw_writer_asserts
bind jmw_writer jmw_writer_asserts i_chk (.SYS_CLK, .SYS_RST, .START, .MODE_FREE, .WORD_COUNT,
	.FIRST_WRITE_ADDRESS, .FLASH_CONTROL_THIRD_VALUE, .IMAGE_BASE, .IMAGE_OFFSET, .LOAD_REQ,
	.PARAM_ADDRESS, .PARAM_LENGTH, .PARAM_FLASH_CONTROL, .CODE_ENTRY, .RELEASE_REQ, .HALT_REQ,
	.BUSY, .DONE, .TCK, .TMS);
`default_nettype wire

// file: tb/jmw_target.sv
// Target model: TAP, mailbox and running flash-write code
`timescale 1ns/1ps
`default_nettype none
`include "jmw_regs.vh"
module jmw_target (
	input  wire logic        clk,
	input  wire logic        tck,
	input  wire logic        tms,
	input  wire logic        tdi,
	input  wire logic        released,
	input  wire logic        halt,
	input  wire logic [15:0] delay,
	output var  logic        tdo
);
	localparam logic [63:0] NX1 = 64'h2FEFCC0287855920;
	localparam logic [63:0] NX0 = 64'h1BDDBBA146644311;
	logic [3:0]  st = 4'h1;
	logic [7:0]  ir = 8'h00;
	logic [15:0] sr = 16'h0000;
	logic [15:0] words [64];
	logic        phase = 1'b0;
	logic        run = 1'b0;
	logic        tckp = 1'b0;
	logic        tdip = 1'b0;
	int          nw = 0;
	int          bad = 0;
	int          need = 0;
	int          span = 0;
	int          mins = 1000000;
	initial tdo = 1'b0;
	// TAP walk, shifts and mailbox words on the link clock
	always @(posedge tck) begin
		if (st == 4'hB) ir <= {tdi, ir[7:1]};
		if (st == 4'h4) sr <= {sr[14:0], tdi};
		if (st == 4'h3) sr <= {~nw[14:0], need == 0};
		if (st == 4'h8 && ir == `JMW_MAILBOX_EXCHANGE_INSTRUCTION) begin
			if (phase) begin
				words[nw] <= sr;
				nw <= nw + 1;
				bad <= bad + (need != 0);
				need <= released ? delay : `JMW_TEST_CLOCKS;
				phase <= 1'b0;
			end else if (sr == `JMW_INPUT_REQUEST) phase <= 1'b1;
			else if (sr != `JMW_POLL_WORD) bad <= bad + 1;
		end
		st <= tms ? NX1[st*4+:4] : NX0[st*4+:4];
	end
	// Code runs on own clock when released, on test clocks otherwise
	always @(posedge clk) begin
		tckp <= tck;
		tdip <= tdi;
		if (released && need > 0) need <= need - 1;
		if (!released && st == 4'h1 && !tck && tdi && !tdip && need > 0) begin
			need <= need - 1;
			run <= 1'b1;
		end
		if (run) span <= span + 1;
		if (run && ((tck && !tckp) || halt)) begin
			mins <= span < mins ? span : mins;
			run <= 1'b0;
			span <= 0;
		end
	end
	// Read bits leave on the falling edge; outside DR shifts the line toggles
	always @(negedge tck) tdo <= (st == 4'h4) ? sr[15] : ~tdo;
endmodule // jmw_target
`default_nettype wire

// file: tb/jmw_writer_tb.sv
// Self-checking bench for the mailbox flash word writer
`timescale 1ns/1ps
`default_nettype none
`include "jmw_regs.vh"
module jmw_writer_tb;
	localparam int TW = 120;
	logic        SYS_CLK = 1'b0;
	logic        SYS_RST = 1'b1;
	logic        START = 1'b0;
	logic        MODE_FREE = 1'b0;
	logic [15:0] WORD_COUNT = 16'h0000;
	logic [19:0] FIRST_WRITE_ADDRESS = 20'h00000;
	logic [15:0] FLASH_CONTROL_THIRD_VALUE = 16'h0000;
	logic [19:0] IMAGE_BASE = 20'h00000;
	logic [15:0] IMAGE_OFFSET = 16'h0000;
	logic        LOAD_DONE = 1'b0;
	logic        IN_VALID = 1'b0;
	logic [15:0] IN_DATA = 16'h0000;
	logic [15:0] delay = 16'h0000;
	logic        gate = 1'b0;
	wire logic   IN_READY, LOAD_REQ, RELEASE_REQ, HALT_REQ, BUSY, DONE, TCK, TMS, TDI, TDO;
	wire logic [19:0] PARAM_ADDRESS, CODE_ENTRY;
	wire logic [15:0] PARAM_LENGTH, PARAM_FLASH_CONTROL;
	int          num_errors = 0;
	int          tests_run = 0;
	int          seed = 32'h856bd298;
	logic [15:0] exp_q [$];
	jmw_writer #(.TWORD_CYCLES(TW)) i_jmw_writer (.SYS_CLK, .SYS_RST, .START, .MODE_FREE, .WORD_COUNT,
		.FIRST_WRITE_ADDRESS, .FLASH_CONTROL_THIRD_VALUE, .IMAGE_BASE, .IMAGE_OFFSET, .LOAD_DONE,
		.IN_VALID, .IN_DATA, .IN_READY, .LOAD_REQ, .PARAM_ADDRESS, .PARAM_LENGTH, .PARAM_FLASH_CONTROL,
		.CODE_ENTRY, .RELEASE_REQ, .HALT_REQ, .BUSY, .DONE, .TCK, .TMS, .TDI, .TDO);
	jmw_target i_jmw_target (.clk(SYS_CLK), .tck(TCK), .tms(TMS), .tdi(TDI), .released(RELEASE_REQ),
		.halt(HALT_REQ), .delay(delay), .tdo(TDO));
	always #10 SYS_CLK = ~SYS_CLK;
	// Loader answers a load request once the bench opens the gate
	always @(negedge SYS_CLK) LOAD_DONE <= LOAD_REQ && gate;
	function automatic logic [19:0] entry(input logic [19:0] b, input logic [15:0] o);
		return b + {4'h0, o};
	endfunction
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic push(input logic [15:0] d);
		int k;
		IN_VALID = 1'b1;
		IN_DATA = d;
		for (k = 0; k < 20000 && IN_READY !== 1'b1; k++) @(negedge SYS_CLK);
		@(negedge SYS_CLK);
	endtask
	task automatic job(input logic fr, input int n, input logic [15:0] dl);
		int base;
		int k;
		base = i_jmw_target.nw;
		exp_q.delete();
		for (k = 0; k < n; k++) exp_q.push_back(16'($random(seed)));
		gate = 1'b0;
		delay = dl;
		MODE_FREE = fr;
		WORD_COUNT = n[15:0];
		FIRST_WRITE_ADDRESS = 20'($random(seed));
		FLASH_CONTROL_THIRD_VALUE = 16'($random(seed));
		IMAGE_BASE = 20'($random(seed));
		IMAGE_OFFSET = 16'($random(seed));
		START = 1'b1;
		@(negedge SYS_CLK);
		START = 1'b0;
		chk(PARAM_ADDRESS === FIRST_WRITE_ADDRESS && PARAM_LENGTH === WORD_COUNT, "parameters");
		chk(PARAM_FLASH_CONTROL === FLASH_CONTROL_THIRD_VALUE, "flash control value");
		chk(CODE_ENTRY === entry(IMAGE_BASE, IMAGE_OFFSET), "code entry");
		for (k = 0; k < n; k++) begin
			if (k == 4) begin
				chk(IN_READY === 1'b0 && LOAD_REQ === 1'b1, "full buffer or load");
				gate = 1'b1;
			end
			push(exp_q[k]);
		end
		IN_VALID = 1'b0;
		gate = 1'b1;
		if (n > 0) begin
			repeat (4) @(negedge SYS_CLK);
			WORD_COUNT = 16'hFFFF;
			START = 1'b1;
			@(negedge SYS_CLK);
			START = 1'b0;
			chk(PARAM_LENGTH === n[15:0] && RELEASE_REQ === fr, "busy start or mode");
		end
		for (k = 0; k < 60000 && DONE !== 1'b1; k++) @(negedge SYS_CLK);
		chk(DONE === 1'b1 && HALT_REQ === 1'b1, "end and halt");
		chk(i_jmw_target.nw - base === n, "word count");
		for (k = 0; k < n; k++) chk(i_jmw_target.words[base + k] === exp_q[k], "word data");
		@(negedge SYS_CLK);
		chk(BUSY === 1'b0, "still busy");
		$display("test done mode %0d words %0d", fr, n);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Main sequence: corner jobs, then random ones
	initial begin
		repeat (8) @(negedge SYS_CLK);
		SYS_RST = 1'b0;
		chk(BUSY === 1'b0 && IN_READY === 1'b1 && TCK === 1'b0, "reset state");
		job(1'b0, 5, 16'h0000);
		job(1'b1, 6, 16'h0190);
		job(1'b1, 3, 16'h0000);
		job(1'b0, 0, 16'h0000);
		repeat (3) job(1'($random(seed)), 1 + ($random(seed) & 3), 16'($random(seed) & 255));
		chk(i_jmw_target.bad === 0, "mailbox order or pacing");
		chk(i_jmw_target.mins >= TW, "test clock spread");
		tally_and_finish();
	end
	// Watchdog cuts a hang short
	initial begin
		#1800000;
		num_errors++;
		tally_and_finish();
	end
endmodule // jmw_writer_tb
`default_nettype wire
